// >>> core/spu_pkg.sv
// Constants and types shared by the serial port unit
package spu_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 25;   // System clock period
    localparam int SCK_HALF_NS    = 100;  // Least serial clock half period
    localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int EDGES_PER_BYTE = 16;   // Eight full clock periods

    localparam logic [3:0] HC_LAST   = 4'(SCK_HALF_CYC - 1);
    localparam logic [3:0] EDGE_LAST = 4'(EDGES_PER_BYTE - 1);
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // ------------------------------------------------------------
    // Select mode encodings and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_3WIRE  = 2'h0;  // Select line unused
    localparam logic [1:0] SEL_MULTI  = 2'h1;  // Select line is input
    localparam int         SEL_UP_POS = 1;     // Set: select is output
    localparam int         SEL_LO_POS = 0;     // Output select level

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       port_enable_bit;
        logic       master_enable_bit;
        logic [1:0] select_mode_field;
        logic       clock_polarity_bit;
        logic       clock_phase_bit;
    } spu_cfg_t;

    typedef struct packed {
        logic transfer_complete_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
    } spu_flags_t;

    typedef struct packed {
        logic oe;  // High while driving
        logic o;   // Level driven
    } spu_pin_t;

    typedef enum logic {ST_IDLE, ST_SHIFT} spu_state_t;

    localparam spu_cfg_t   CFG_RST   = '0;
    localparam spu_flags_t FLAGS_RST = '0;

endpackage : spu_pkg

// >>> core/spu_serial_port_unit.sv
// Serial port unit: master engine, slave link side and pin control
`timescale 1ns/10ps
module spu_serial_port_unit
(
    input  wire logic            CLK_SYS_I,     // System clock
    input  wire logic            RSTN_I,        // Async reset, low
    input  wire logic            SCK_I,         // Serial clock from pin
    input  wire logic            CFG_WR_I,      // Load configuration
    input  wire spu_pkg::spu_cfg_t CFG_I,       // Configuration value
    input  wire logic            INT_EN_I,      // Interrupt enable
    input  wire logic            DATA_WR_I,     // Data write strobe
    input  wire logic [7:0]      DATA_I,        // Data to send
    output logic [7:0]           RX_DATA_O,     // Receive buffer
    input  wire spu_pkg::spu_flags_t FLAG_CLR_I, // Flag clear pulses
    output spu_pkg::spu_flags_t  FLAGS_O,       // Sticky flags
    output logic                 IRQ_O,         // Interrupt request
    output spu_pkg::spu_cfg_t    CFG_O,         // Live configuration
    output logic                 BUSY_O,        // Master transfer
    input  wire logic            MOSI_I,        // Master-out pin in
    input  wire logic            MISO_I,        // Master-in pin in
    input  wire logic            NSS_I,         // Select pin in
    output spu_pkg::spu_pin_t    MOSI_PIN_O,    // Master-out drive
    output spu_pkg::spu_pin_t    MISO_PIN_O,    // Master-in drive
    output spu_pkg::spu_pin_t    SCK_PIN_O,     // Serial clock drive
    output spu_pkg::spu_pin_t    NSS_PIN_O,     // Select drive
    output logic                 NSS_ROUTED_O   // Select has a pin
);
    import spu_pkg::*;

    localparam int BYTE_CYC = EDGES_PER_BYTE * SCK_HALF_CYC;

    spu_cfg_t   cfg_q;
    spu_flags_t flags_q;
    spu_state_t state_q;
    logic [7:0] txb_q, sh_q, rx_sh_q, rxb_q, slv_tx_q, rx_next;
    logic [3:0] hc_q, edge_q;
    logic       txb_full_q, sck_q, slv_ld_q;
    logic       miso_s1_q, miso_s2_q, nss_s1_q, nss_s2_q;
    logic       tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic       mst_ok, mst_load, edge_now, done_p, samp_edge;
    logic       shift_edge, slv_role, slv_evt, slv_load;
    logic       fault, write_collision_flag_set, lk_sel;
    logic [6:0] byte_cyc_q;

    // ------------------------------------------------------------
    // Pin input synchronisers and slave byte event crossing
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
            nss_s1_q  <= 1'b1;
            nss_s2_q  <= 1'b1;
            tgl_s1_q  <= 1'b0;
            tgl_s2_q  <= 1'b0;
            tgl_s3_q  <= 1'b0;
        end
        else
        begin
            miso_s1_q <= MISO_I;
            miso_s2_q <= miso_s1_q;
            nss_s1_q  <= NSS_I;
            nss_s2_q  <= nss_s1_q;
            tgl_s1_q  <= lk_tgl_q;
            tgl_s2_q  <= tgl_s1_q;
            tgl_s3_q  <= tgl_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    assign mst_ok   = cfg_q.port_enable_bit & cfg_q.master_enable_bit;
    assign slv_role = cfg_q.port_enable_bit & ~cfg_q.master_enable_bit;
    assign fault    = mst_ok & (cfg_q.select_mode_field == SEL_MULTI)
                    & ~nss_s2_q;
    assign write_collision_flag_set = DATA_WR_I & txb_full_q;
    assign mst_load = (state_q == ST_IDLE) & mst_ok & txb_full_q;
    assign slv_load = slv_role & ~slv_ld_q & txb_full_q;
    assign edge_now = (state_q == ST_SHIFT) & mst_ok & (hc_q == HC_LAST);
    assign done_p   = edge_now & (edge_q == EDGE_LAST);
    // Phase picks even or odd edges for sampling
    assign samp_edge  = edge_now
                      & (edge_q[0] == cfg_q.clock_phase_bit);
    assign shift_edge = edge_now & (edge_q[0] != cfg_q.clock_phase_bit)
                      & ~(cfg_q.clock_phase_bit & (edge_q == 4'h0));
    // Slave data arrives on master-in during the same byte
    assign rx_next  = samp_edge ? {rx_sh_q[6:0], miso_s2_q}
                                : rx_sh_q;

    // ------------------------------------------------------------
    // Configuration; hardware clears enables on a fault
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            cfg_q <= CFG_RST;
        else if (fault)
        begin
            cfg_q.port_enable_bit   <= 1'b0;
            cfg_q.master_enable_bit <= 1'b0;
        end
        else if (CFG_WR_I)
            cfg_q <= CFG_I;
    end

    // ------------------------------------------------------------
    // Transmit buffer; a write to a full buffer is dropped
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            txb_q      <= DATA_RST;
            txb_full_q <= 1'b0;
        end
        else if (DATA_WR_I && !txb_full_q)
        begin
            txb_q      <= DATA_I;
            txb_full_q <= 1'b1;
        end
        else if (mst_load || slv_load)
            txb_full_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Master engine: clock divider, edge count, shifters
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            state_q <= ST_IDLE;
            hc_q    <= 4'h0;
            edge_q  <= 4'h0;
            sck_q   <= 1'b0;
            sh_q    <= DATA_RST;
            rx_sh_q <= DATA_RST;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    hc_q   <= 4'h0;
                    edge_q <= 4'h0;
                    sck_q  <= cfg_q.clock_polarity_bit;
                    if (mst_load)
                    begin
                        sh_q    <= txb_q;
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (!mst_ok)
                        state_q <= ST_IDLE;
                    else if (hc_q != HC_LAST)
                        hc_q <= hc_q + 4'h1;
                    else
                    begin
                        hc_q    <= 4'h0;
                        edge_q  <= edge_q + 4'h1;
                        sck_q   <= ~sck_q;
                        rx_sh_q <= rx_next;
                        if (shift_edge)
                            sh_q <= {sh_q[6:0], 1'b0};
                        if (edge_q == EDGE_LAST)
                            state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Slave link side, clocked by the incoming serial clock
    // ------------------------------------------------------------
    logic       lk_clk, lk_rst_n, lk_tgl_q;
    logic [6:0] lk_sh_q;
    logic [7:0] lk_rx_q;
    logic [2:0] lk_cnt_q, lk_idx_q;

    // Sample edge of the serial clock becomes the rising edge
    assign lk_clk   = SCK_I ^ (cfg_q.clock_polarity_bit
                              ^ cfg_q.clock_phase_bit);
    assign lk_sel   = (cfg_q.select_mode_field == SEL_3WIRE)
                    | ~NSS_I;
    // Unselected or disabled slave holds its bit counter cleared
    assign lk_rst_n = RSTN_I & slv_role & lk_sel;

    // Bit counter and receive shifter
    always_ff @(posedge lk_clk or negedge lk_rst_n)
    begin
        if (!lk_rst_n)
        begin
            lk_cnt_q <= 3'h0;
            lk_sh_q  <= 7'h00;
        end
        else
        begin
            lk_cnt_q <= lk_cnt_q + 3'h1;
            lk_sh_q  <= {lk_sh_q[5:0], MOSI_I};
        end
    end

    // Completed byte and event toggle survive deselection
    always_ff @(posedge lk_clk or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            lk_rx_q  <= DATA_RST;
            lk_tgl_q <= 1'b0;
        end
        else if (lk_rst_n && lk_cnt_q == BIT_LAST)
        begin
            lk_rx_q  <= {lk_sh_q, MOSI_I};
            lk_tgl_q <= ~lk_tgl_q;
        end
    end

    // Output bit index advances on the launch edge
    always_ff @(negedge lk_clk or negedge lk_rst_n)
    begin
        if (!lk_rst_n)
            lk_idx_q <= 3'h0;
        else
            lk_idx_q <= lk_cnt_q;
    end

    // ------------------------------------------------------------
    // Slave byte event crossing and slave transmit byte
    // ------------------------------------------------------------
    // Toggle change marks a finished slave byte
    assign slv_evt = tgl_s2_q ^ tgl_s3_q;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            slv_tx_q <= DATA_RST;
            slv_ld_q <= 1'b0;
        end
        else if (!slv_role || slv_evt)
            slv_ld_q <= 1'b0;
        else if (slv_load)
        begin
            slv_tx_q <= txb_q;
            slv_ld_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Receive buffer and sticky flags; a set beats a clear
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            rxb_q <= DATA_RST;
        else if (done_p)
            rxb_q <= rx_next;
        else if (slv_evt)
            rxb_q <= lk_rx_q;
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            flags_q <= FLAGS_RST;
        else
            flags_q <= spu_flags_t'((flags_q & ~FLAG_CLR_I)
                     | {done_p | slv_evt, write_collision_flag_set, fault});
    end

    // ------------------------------------------------------------
    // Outputs and pin drive
    // ------------------------------------------------------------
    assign RX_DATA_O = rxb_q;
    assign FLAGS_O   = flags_q;
    assign CFG_O     = cfg_q;
    assign BUSY_O    = (state_q == ST_SHIFT);
    assign IRQ_O     = INT_EN_I & (|flags_q);

    assign MOSI_PIN_O.oe = mst_ok;
    assign MOSI_PIN_O.o  = sh_q[7];
    assign SCK_PIN_O.oe  = mst_ok;
    assign SCK_PIN_O.o   = sck_q;
    // Master-in driven only by a selected slave
    assign MISO_PIN_O.oe = slv_role & lk_sel;
    assign MISO_PIN_O.o  = slv_tx_q[3'(BIT_LAST - lk_idx_q)];
    // Select output follows the lower mode bit, in master or slave role
    assign NSS_PIN_O.oe  = cfg_q.port_enable_bit
                         & cfg_q.select_mode_field[SEL_UP_POS];
    assign NSS_PIN_O.o   = cfg_q.select_mode_field[SEL_LO_POS];
    assign NSS_ROUTED_O  = (cfg_q.select_mode_field != SEL_3WIRE);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    // Assertion helper: cycles spent shifting the current byte
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            byte_cyc_q <= 7'h00;
        else if (state_q == ST_SHIFT)
            byte_cyc_q <= byte_cyc_q + 7'h01;
        else
            byte_cyc_q <= 7'h00;
    end

    sequence s_start;
        mst_load;
    endsequence

    sequence s_shifting;
        (state_q == ST_SHIFT) && (sh_q == $past(txb_q));
    endsequence

    AST_MOSI_DIR: assert property (mst_load && !fault && !CFG_WR_I
        |=> MOSI_PIN_O.oe && MOSI_PIN_O.o == $past(txb_q[7]))
        else $error("master-out not driven from byte MSB");
    AST_MISO_DIR: assert property (mst_ok |-> !MISO_PIN_O.oe)
        else $error("master-in driven in master role");
    AST_MISO_HIZ: assert property (!cfg_q.port_enable_bit
        |-> !MISO_PIN_O.oe)
        else $error("master-in driven while disabled");
    AST_MISO_3W: assert property (slv_role
        && cfg_q.select_mode_field == SEL_3WIRE |-> MISO_PIN_O.oe)
        else $error("three-wire slave not driving");
    AST_NSS_OUT: assert property (cfg_q.port_enable_bit
        && cfg_q.select_mode_field[SEL_UP_POS]
        |-> NSS_PIN_O.oe
        && NSS_PIN_O.o == cfg_q.select_mode_field[SEL_LO_POS])
        else $error("select output wrong");
    AST_FAULT: assert property (fault && !CFG_WR_I |=>
        !cfg_q.master_enable_bit && !cfg_q.port_enable_bit
        && flags_q.mode_fault_flag)
        else $error("mode fault not handled");
    AST_WRITE_COLLISION_FLAG: assert property (write_collision_flag_set |=>
        flags_q.write_collision_flag && $stable(txb_q))
        else $error("collision not flagged or write taken");
    AST_START: assert property (s_start |=> s_shifting)
        else $error("transfer did not start from buffer");
    AST_BYTE_LEN: assert property ((state_q == ST_SHIFT) && mst_ok
        |-> done_p == (byte_cyc_q == 7'(BYTE_CYC - 1)))
        else $error("byte length not eight clock periods");
    AST_IDLE_CLK: assert property (done_p |=>
        sck_q == cfg_q.clock_polarity_bit)
        else $error("serial clock not back to idle");
    AST_DONE_FLAG: assert property (done_p |=>
        flags_q.transfer_complete_flag && rxb_q == $past(rx_next))
        else $error("complete flag or receive byte missing");
    AST_CHAIN: assert property (done_p && txb_full_q
        && cfg_q.master_enable_bit && !fault ##1 mst_ok
        |=> state_q == ST_SHIFT)
        else $error("waiting byte not started");
    AST_IRQ: assert property (INT_EN_I && flags_q.mode_fault_flag
        |-> IRQ_O)
        else $error("fault interrupt missing");

endmodule : spu_serial_port_unit

// >>> tb/spu_slave_model.sv
// Slave device model facing the master engine
`timescale 1ns/10ps
module spu_slave_model
(
    input  wire logic        sck_i,   // Serial clock from master
    input  wire logic        mosi_i,  // Master-out line
    input  wire logic        sel_i,   // Slave taking part
    input  wire logic        pol_i,   // Clock idle level
    input  wire logic        pha_i,   // Clock phase
    input  wire logic [15:0] tx_i,    // Bytes to return
    output logic             miso_o,  // Master-in line
    output logic [15:0]      rx_o     // Bytes captured
);
    logic [15:0] sr;
    logic        lead;

    initial
    begin
        miso_o = 1'b0;
        rx_o   = 16'h0000;
        sr     = 16'h0000;
    end

    // Load at select, released line shows inverse of last bit
    always @(sel_i)
    begin
        if (sel_i)
        begin
            sr   = tx_i;
            rx_o = 16'h0000;
            if (!pha_i)
            begin
                miso_o = sr[15];
                sr     = sr << 1;
            end
        end
        else
            miso_o = ~miso_o;
    end

    // Clock only received; sample or launch by phase
    always @(sck_i)
    begin
        lead = (sck_i !== pol_i);
        if (sel_i && (lead ^ pha_i))
            rx_o = {rx_o[14:0], mosi_i};
        else if (sel_i)
        begin
            miso_o = sr[15];
            sr     = sr << 1;
        end
    end
endmodule : spu_slave_model

// >>> tb/spu_serial_port_unit_tb_top.sv
// Self-checking bench for the serial port unit
`timescale 1ns/10ps
module spu_serial_port_unit_tb_top;
    import spu_pkg::*;
    logic        clk, rstn, cfg_wr, int_en, data_wr, sel, cnt_en;
    logic        tb_sck, tb_mosi, tb_nss, irq, busy, routed;
    spu_cfg_t    cfg, cfg_q;
    spu_flags_t  clr, flags;
    spu_pin_t    mosi_p, miso_p, sck_p, nss_p;
    logic [7:0]  din, rx, a, b, sa, sb, so, sgot;
    logic [15:0] tx16, rx16;
    wire         sck_w, mosi_w, miso_w, nss_w, m_miso;
    int          n_mismatch, checked, n_edge;

    // Wire levels from every driver
    assign sck_w  = sck_p.oe ? sck_p.o : tb_sck;
    assign mosi_w = mosi_p.oe ? mosi_p.o : tb_mosi;
    assign miso_w = miso_p.oe ? miso_p.o : m_miso;
    assign nss_w  = nss_p.oe ? nss_p.o : tb_nss;

    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    always @(sck_w) if (cnt_en) n_edge++;

    spu_serial_port_unit u_spu_serial_port_unit (
        .CLK_SYS_I(clk), .RSTN_I(rstn), .SCK_I(sck_w), .CFG_WR_I(cfg_wr),
        .CFG_I(cfg), .INT_EN_I(int_en), .DATA_WR_I(data_wr), .DATA_I(din),
        .RX_DATA_O(rx), .FLAG_CLR_I(clr), .FLAGS_O(flags), .IRQ_O(irq),
        .CFG_O(cfg_q), .BUSY_O(busy), .MOSI_I(mosi_w), .MISO_I(miso_w),
        .NSS_I(nss_w), .MOSI_PIN_O(mosi_p), .MISO_PIN_O(miso_p),
        .SCK_PIN_O(sck_p), .NSS_PIN_O(nss_p), .NSS_ROUTED_O(routed));

    spu_slave_model u_spu_slave_model (
        .sck_i(sck_w), .mosi_i(mosi_w), .sel_i(sel), .pol_i(cfg_q[1]),
        .pha_i(cfg_q[0]), .tx_i(tx16), .miso_o(m_miso), .rx_o(rx16));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    function automatic spu_cfg_t mk(input logic pe, input logic me,
        input logic [1:0] md, input logic pol, input logic pha);
        mk = {pe, me, md, pol, pha};
    endfunction : mk

    task automatic setcfg(input spu_cfg_t c);
        @(negedge clk) cfg = c;
        cfg_wr = 1'b1;
        @(negedge clk) cfg_wr = 1'b0;
        @(negedge clk);
    endtask : setcfg

    task automatic wr(input logic [7:0] d);
        @(negedge clk) din = d;
        data_wr = 1'b1;
        @(negedge clk) data_wr = 1'b0;
    endtask : wr

    task automatic clrf;
        @(negedge clk) clr = 3'h7;
        @(negedge clk) clr = 3'h0;
    endtask : clrf

    // Bounded wait on the byte-end flag
    task automatic wait_done;
        int i;
        for (i = 0; i < 300 && flags.transfer_complete_flag !== 1'b1; i++)
            @(negedge clk);
        if (i == 300)
        begin
            n_mismatch++;
            $display("MISMATCH wait_done timed out");
            test_done();
        end
    endtask : wait_done

    // One byte from an outside master, link clock at 48 ns
    task automatic sframe(input logic [7:0] v);
        #7;
        for (int i = 7; i >= 0; i--)
        begin
            tb_mosi = v[i];
            #24 sgot = {sgot[6:0], miso_w};
            tb_sck = 1'b1;
            #24 tb_sck = 1'b0;
        end
        tb_mosi = ~tb_mosi;
    endtask : sframe

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rstn, cfg_wr, int_en, data_wr, sel, cnt_en} = '0;
        {tb_sck, tb_mosi, tb_nss, cfg, clr, din, tx16} = '0;
        tb_nss = 1'b1;
        n_mismatch = 0;
        checked = 0;
        n_edge = 0;
        void'($urandom(32'hB333D3DC));
        cycles(3);
        chk("reset", 0, {cfg_q, flags, busy, mosi_p.oe, miso_p.oe,
            sck_p.oe, nss_p.oe});
        rstn = 1'b1;
        // Master pairs over every polarity and phase
        for (int k = 0; k < 4; k++)
        begin
            a  = (k == 0) ? 8'h80 : 8'($urandom);
            b  = (k == 0) ? 8'h01 : 8'($urandom);
            sa = 8'($urandom);
            sb = (k == 3) ? 8'hFF : 8'($urandom);
            setcfg(mk(1'b1, 1'b1, {1'b1, k[0]}, k[1], k[0]));
            tx16 = {sa, sb};
            sel = 1'b1;
            int_en = k[1];
            n_edge = 0;
            cnt_en = 1'b1;
            chk("pins", {5'h17, k[0], 1'b1, k[1]}, {mosi_p.oe, miso_p.oe,
                sck_p.oe, nss_p.oe, 1'b1, nss_p.o, routed, sck_w});
            wr(a);
            cycles(2);
            chk("busy", 1, busy);
            wr(b);
            wr(8'($urandom));
            cycles(2);
            chk("write_collision_flag", 1, flags.write_collision_flag);
            wait_done();
            chk("rx0", {sa, k[1]}, {rx, irq});
            clrf();
            wait_done();
            chk("rx1", sb, rx);
            cycles(4);
            chk("edges", 32, n_edge);
            chk("idle", {1'b0, k[1]}, {busy, sck_w});
            chk("mosi", {a, b}, rx16);
            cnt_en = 1'b0;
            sel = 1'b0;
            clrf();
        end
        // Competing master pulls select low mid-byte
        int_en = 1'b1;
        setcfg(mk(1'b1, 1'b1, SEL_MULTI, 1'b0, 1'b0));
        wr(8'h5A);
        cycles(20);
        tb_nss = 1'b0;
        cycles(6);
        chk("fault", 7'h18, {cfg_q.port_enable_bit, cfg_q.master_enable_bit,
            flags.mode_fault_flag, irq, busy, miso_p.oe, sck_p.oe});
        tb_nss = 1'b1;
        cycles(10);
        chk("stay", 0, {cfg_q.port_enable_bit, cfg_q.master_enable_bit});
        clrf();
        // Slave role, four-wire then three-wire
        setcfg(mk(1'b1, 1'b0, SEL_MULTI, 1'b0, 1'b0));
        chk("unsel", {1'b0, 1'b1}, {miso_p.oe, routed});
        sframe(8'hC3);
        cycles(10);
        chk("ignored", 0, flags.transfer_complete_flag);
        tb_nss = 1'b0;
        cycles(4);
        chk("sel_oe", 1, miso_p.oe);
        so = 8'($urandom);
        wr(so);
        a = 8'($urandom);
        sframe(a);
        wait_done();
        chk("srx", a, rx);
        chk("stx", so, sgot);
        clrf();
        tb_nss = 1'b1;
        setcfg(mk(1'b1, 1'b0, SEL_3WIRE, 1'b0, 1'b0));
        chk("three", {1'b1, 1'b0}, {miso_p.oe, routed});
        a = 8'($urandom);
        sframe(a);
        wait_done();
        chk("trx", a, rx);
        setcfg(mk(1'b0, 1'b0, SEL_3WIRE, 1'b0, 1'b0));
        chk("off", 0, miso_p.oe);
        test_done();
    end
endmodule : spu_serial_port_unit_tb_top
